// [src/ssp_pkg.sv]
package ssp_pkg;
  // Register offsets
  localparam logic [3:0] OFS_CTRL0   = 4'h0;  // Frame size, format, clock phase/polarity
  localparam logic [3:0] OFS_CTRL1   = 4'h1;  // Enable, master/slave, output disable, loopback
  localparam logic [3:0] OFS_DATA    = 4'h2;
  localparam logic [3:0] OFS_STATUS  = 4'h3;
  localparam logic [3:0] OFS_PRESC   = 4'h4;
  localparam logic [3:0] OFS_DIV     = 4'h5;
  localparam logic [3:0] OFS_IRQ_ST  = 4'h6;
  localparam logic [3:0] OFS_IRQ_EN  = 4'h7;
  localparam logic [3:0] OFS_IRQ_CLR = 4'h8;

  // CTRL0 fields
  localparam int CTRL0_SIZE_LSB = 0;   // Frame size minus one, 4 bits
  localparam int CTRL0_FMT_LSB  = 4;   // Frame format, 2 bits
  localparam int CTRL0_POL_BIT  = 6;
  localparam int CTRL0_PHA_BIT  = 7;
  // CTRL1 fields
  localparam int CTRL1_EN_BIT    = 0;
  localparam int CTRL1_SLAVE_BIT = 1;
  localparam int CTRL1_SOD_BIT   = 2;  // Slave output disable
  localparam int CTRL1_LOOP_BIT  = 3;
  // STATUS fields
  localparam int ST_TFE = 0;
  localparam int ST_TNF = 1;
  localparam int ST_RNE = 2;
  localparam int ST_RFF = 3;
  localparam int ST_BSY = 4;
  // Interrupt bits
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_TX_EMPTY = 1;
  localparam int IRQ_RX_OVR = 2;
  localparam int IRQ_W = 3;

  // Size limits and reset values
  localparam logic [3:0] SIZE_MIN_M1  = 4'h3;  // Four-bit frames
  localparam logic [7:0] CTRL0_RESET  = 8'h07;
  localparam logic [3:0] CTRL1_RESET  = 4'h0;
  localparam logic [7:0] PRESC_RESET  = 8'h02;
  localparam logic [7:0] DIV_RESET    = 8'h00;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W     = 16;

  typedef enum logic [1:0] {
    FMT_SPI,
    FMT_THREE_WIRE,   // three_wire_micro_format
    FMT_FRAME_PULSE,
    FMT_RSVD
  } frame_fmt_t;
endpackage

// [src/fifo_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Push/pop bundle between the port core and one FIFO
interface fifo_if #(parameter int W = 16);
  logic         push;
  logic [W-1:0] wdata;
  logic         pop;
  logic [W-1:0] rdata;
  logic         empty;
  logic         full;
  modport owner (input push, input wdata, input pop, output rdata, output empty, output full);
  modport user  (output push, output wdata, output pop, input rdata, input empty, input full);
endinterface
`default_nettype wire

// [src/word_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// Small first-word-fall-through FIFO; read data held in a register
module word_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic flush,
  fifo_if.owner     f
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic [W-1:0]  rd_q;
  wire do_push = f.push && !f.full;
  wire do_pop  = f.pop && !f.empty;
  wire [AW-1:0] rp_nx = do_pop ? AW'(rp_q + 1'b1) : rp_q;

  assign f.empty = (cnt_q == '0);
  assign f.full  = (cnt_q == (AW+1)'(DEPTH));
  assign f.rdata = rd_q;

  // Pointers and count; push into a full FIFO is dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (clk_en && flush)) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (clk_en) begin
      if (do_push) begin
        mem_q[wp_q] <= f.wdata;
        wp_q        <= AW'(wp_q + 1'b1);
      end
      rp_q  <= rp_nx;
      cnt_q <= (AW+1)'(cnt_q + do_push - do_pop);
    end
  end

  // Registered head word; bypass the write when empty
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_q <= '0;
    end else if (clk_en) begin
      if (do_push && ((cnt_q == '0) || (cnt_q == 1 && do_pop)))
        rd_q <= f.wdata;
      else
        rd_q <= mem_q[rp_nx];
    end
  end
endmodule
`default_nettype wire

// [src/sync_serial_port.sv]
// Behaviour
// - Frame format is chosen among SPI, three-wire micro format and frame-pulse format.
// - Frame length is programmable from 4 to 16 bits and both ends must agree.
// - Received bits are assembled into words and queued words are shifted out serially.
// - Transmit and receive each have their own eight-entry 16-bit FIFO.
// - The port works as master generating clock and framing, or as slave following them.
// - As slave the serial data output can be disabled to share the line.
// - Master serial clock comes from a prescaler followed by a bit-rate divider.
// - A loopback mode routes transmitted data back into the receiver internally.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port #(
  parameter int DEPTH = ssp_pkg::FIFO_DEPTH
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             irq,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe_n,
  input  wire logic        fss_in,
  output logic             fss_out,
  output logic             fss_oe_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe_n
);
  localparam int W = ssp_pkg::WORD_W;

  logic [7:0]  ctrl0_q;
  logic [3:0]  ctrl1_q;
  logic [7:0]  presc_q;
  logic [7:0]  div_q;
  logic [ssp_pkg::IRQ_W-1:0] ist_q;
  logic [ssp_pkg::IRQ_W-1:0] ien_q;
  logic [15:0] rdata_q;

  fifo_if #(.W(W)) txf ();
  fifo_if #(.W(W)) rxf ();

  // Register decode
  wire wr_ctrl0 = reg_wr && (reg_addr == ssp_pkg::OFS_CTRL0);
  wire wr_ctrl1 = reg_wr && (reg_addr == ssp_pkg::OFS_CTRL1);
  wire wr_data  = reg_wr && (reg_addr == ssp_pkg::OFS_DATA);
  wire wr_presc = reg_wr && (reg_addr == ssp_pkg::OFS_PRESC);
  wire wr_div   = reg_wr && (reg_addr == ssp_pkg::OFS_DIV);
  wire wr_ien   = reg_wr && (reg_addr == ssp_pkg::OFS_IRQ_EN);
  wire wr_iclr  = reg_wr && (reg_addr == ssp_pkg::OFS_IRQ_CLR);
  wire rd_data  = reg_rd && (reg_addr == ssp_pkg::OFS_DATA);

  // Configuration fields
  wire [3:0] size_m1 = ctrl0_q[ssp_pkg::CTRL0_SIZE_LSB +: 4];
  wire [1:0] fmt     = ctrl0_q[ssp_pkg::CTRL0_FMT_LSB +: 2];
  wire       cpol    = ctrl0_q[ssp_pkg::CTRL0_POL_BIT];
  wire       cpha    = ctrl0_q[ssp_pkg::CTRL0_PHA_BIT];
  wire       enable  = ctrl1_q[ssp_pkg::CTRL1_EN_BIT];
  wire       slave   = ctrl1_q[ssp_pkg::CTRL1_SLAVE_BIT];
  wire       sod     = ctrl1_q[ssp_pkg::CTRL1_SOD_BIT];
  wire       loop    = ctrl1_q[ssp_pkg::CTRL1_LOOP_BIT];
  wire is_spi   = (fmt == 2'(ssp_pkg::FMT_SPI));
  wire is_micro = (fmt == 2'(ssp_pkg::FMT_THREE_WIRE));
  wire is_pulse = (fmt == 2'(ssp_pkg::FMT_FRAME_PULSE));

  // Control registers; sizes under four are raised to four
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl0_q <= ssp_pkg::CTRL0_RESET;
      ctrl1_q <= ssp_pkg::CTRL1_RESET;
      presc_q <= ssp_pkg::PRESC_RESET;
      div_q   <= ssp_pkg::DIV_RESET;
      ien_q   <= '0;
    end else if (clk_en) begin
      if (wr_ctrl0) begin
        ctrl0_q <= reg_wdata[7:0];
        if (reg_wdata[3:0] < ssp_pkg::SIZE_MIN_M1)
          ctrl0_q[3:0] <= ssp_pkg::SIZE_MIN_M1;
      end
      if (wr_ctrl1) ctrl1_q <= reg_wdata[3:0];
      if (wr_presc) presc_q <= (reg_wdata[7:1] == 7'h00) ? 8'h02 : {reg_wdata[7:1], 1'b0};
      if (wr_div)   div_q   <= reg_wdata[7:0];
      if (wr_ien)   ien_q   <= reg_wdata[ssp_pkg::IRQ_W-1:0];
    end
  end

  // Master clock generation: prescale tick then divide
  logic [7:0] pcnt_q;
  logic [7:0] dcnt_q;
  wire ptick = (pcnt_q == 8'(presc_q - 8'h01));
  // half-bit tick = prescaler x (divider + 1)
  wire half_tick = ptick && (dcnt_q == div_q);

  // Slave side: edge detection of the external serial clock; frame input only registered
  logic sclk_d_q;
  logic fss_d_q;
  wire s_edge_rise = sclk_in && !sclk_d_q;
  wire s_edge_fall = !sclk_in && sclk_d_q;

  // Shifter state
  typedef enum logic [1:0] {IDLE, FRAME, SHIFT, DONE} shift_state_t;
  shift_state_t st_q;
  logic [W-1:0] tsh_q;
  logic [W-1:0] rsh_q;
  logic [4:0]   bit_q;
  logic         phase_q;   // Master serial clock level relative to idle
  logic         push_q;    // Received word complete, pushed one cycle later
  logic         fs_q;
  logic         so_q;

  // Capture and launch edges: leading edge samples in SPI format when phase is 0
  wire lead_edge  = slave ? (cpol ? s_edge_fall : s_edge_rise) : (half_tick && !phase_q);
  wire trail_edge = slave ? (cpol ? s_edge_rise : s_edge_fall) : (half_tick && phase_q);
  wire sample_ev  = (is_spi && !cpha) ? lead_edge : trail_edge;
  wire launch_ev  = (is_spi && !cpha) ? trail_edge : lead_edge;
  wire slave_sel  = is_pulse ? fss_in : !fss_in;
  wire rx_bit     = loop ? so_q : sdi;
  wire last_bit   = (bit_q == {1'b0, size_m1});
  wire tx_avail   = !txf.empty;

  // master starts on queued data, slave on select with queued data or on the frame pulse
  wire start = enable && (st_q == IDLE) &&
               (slave ? (is_pulse ? fss_in : (slave_sel && tx_avail)) : (tx_avail && ptick));

  assign txf.pop   = start;
  assign txf.push  = clk_en && wr_data;
  assign txf.wdata = reg_wdata;
  assign rxf.pop   = clk_en && rd_data;
  wire   rx_push   = push_q;
  assign rxf.push  = rx_push;
  // received bits aligned to the right
  assign rxf.wdata = rsh_q;

  // Prescaler counter runs always; divider counter restarts from zero while the shifter is idle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pcnt_q <= '0;
      dcnt_q <= '0;
    end else if (clk_en) begin
      pcnt_q <= ptick ? 8'h00 : 8'(pcnt_q + 8'h01);
      if (ptick) dcnt_q <= (dcnt_q == div_q || st_q == IDLE) ? 8'h00 : 8'(dcnt_q + 8'h01);
    end
  end

  // Serial clock input history; pins are synchronous to ref_clk
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sclk_d_q <= 1'b0;
      fss_d_q  <= 1'b0;
    end else if (clk_en) begin
      sclk_d_q <= sclk_in;
      fss_d_q  <= fss_in;
    end
  end

  // Frame sequencer: load, shift size+1 bits, push received word
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q    <= IDLE;
      tsh_q   <= '0;
      rsh_q   <= '0;
      bit_q   <= '0;
      phase_q <= 1'b0;
      fs_q    <= 1'b0;
      so_q    <= 1'b0;
      push_q  <= 1'b0;
    end else if (clk_en) begin
      // Push waits one cycle so the last sampled bit is in the word
      push_q <= (st_q == SHIFT) && sample_ev && last_bit;
      unique case (st_q)
        IDLE: begin
          phase_q <= 1'b0;
          fs_q    <= 1'b0;
          if (start) begin
            tsh_q <= txf.rdata << (4'hF - size_m1);
            bit_q <= '0;
            rsh_q <= '0;
            // frame pulse leads the frame for one bit time
            fs_q  <= is_pulse && !slave;
            st_q  <= (is_pulse && !slave) ? FRAME : SHIFT;
            so_q  <= (is_spi && !cpha) ? txf.rdata[size_m1] : 1'b0;
            if (is_spi && !cpha) tsh_q <= W'(txf.rdata << (5'd16 - {1'b0, size_m1}));
          end
        end
        FRAME: begin
          if (half_tick) phase_q <= !phase_q;
          // First data bit is launched by the shift state's leading edge
          if (half_tick && phase_q) begin
            fs_q  <= 1'b0;
            st_q  <= SHIFT;
          end
        end
        SHIFT: begin
          if (!slave && half_tick) phase_q <= !phase_q;
          if (launch_ev && !(is_spi && !cpha && bit_q == 0 && !phase_q && !slave)) begin
            so_q  <= tsh_q[W-1];
            tsh_q <= W'(tsh_q << 1);
          end
          if (sample_ev) begin
            rsh_q <= {rsh_q[W-2:0], rx_bit};
            bit_q <= 5'(bit_q + 5'd1);
            if (last_bit) st_q <= DONE;
          end
          // Slave frame aborted when select drops
          if (slave && !is_pulse && !slave_sel) st_q <= IDLE;
          if (!enable) st_q <= IDLE;
        end
        // Master keeps the last clock level for a full half bit
        DONE: begin
          if (slave || half_tick) begin
            phase_q <= 1'b0;
            st_q    <= IDLE;
          end
        end
      endcase
    end
  end

  // Master clock follows the phase flop so the peer sees each edge as we sample
  assign sclk_out  = (is_spi ? cpol : 1'b0) ^ (phase_q && (st_q == SHIFT || st_q == DONE));
  // master drives clock and frame, slave leaves them
  assign sclk_oe_n = slave || !enable;
  assign fss_out   = is_pulse ? fs_q : !(st_q == SHIFT || st_q == DONE) || slave;
  assign fss_oe_n  = slave || !enable;
  assign sdo       = so_q;
  // slave output disable releases the data line
  assign sdo_oe_n  = !enable || loop || (slave && (sod || (!is_pulse && !slave_sel)));

  word_fifo #(.W(W), .DEPTH(DEPTH)) tx_fifo (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .flush   (1'b0),
    .f       (txf)
  );
  word_fifo #(.W(W), .DEPTH(DEPTH)) rx_fifo (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .flush   (1'b0),
    .f       (rxf)
  );

  wire busy = (st_q != IDLE) || (tx_avail && enable && !slave);
  wire [4:0] status = {busy, rxf.full, !rxf.empty, !txf.full, txf.empty};

  // Interrupt events; set wins over a same-cycle clear
  wire [ssp_pkg::IRQ_W-1:0] ev;
  assign ev[ssp_pkg::IRQ_RX_DONE]  = rx_push && !rxf.full;
  assign ev[ssp_pkg::IRQ_TX_EMPTY] = start && tx_avail;
  assign ev[ssp_pkg::IRQ_RX_OVR]   = rx_push && rxf.full;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ist_q <= '0;
    end else if (clk_en) begin
      ist_q <= (ist_q & ~(wr_iclr ? reg_wdata[ssp_pkg::IRQ_W-1:0] : '0)) | ev;
    end
  end
  assign irq = |(ist_q & ien_q);

  // Read mux; unmapped offsets read zero
  logic [15:0] rmux;
  always_comb begin
    unique case (reg_addr)
      ssp_pkg::OFS_CTRL0:  rmux = {8'h00, ctrl0_q};
      ssp_pkg::OFS_CTRL1:  rmux = {12'h000, ctrl1_q};
      ssp_pkg::OFS_DATA:   rmux = rxf.empty ? 16'h0000 : rxf.rdata;
      ssp_pkg::OFS_STATUS: rmux = {11'h000, status};
      ssp_pkg::OFS_PRESC:  rmux = {8'h00, presc_q};
      ssp_pkg::OFS_DIV:    rmux = {8'h00, div_q};
      ssp_pkg::OFS_IRQ_ST: rmux = {13'h0000, ist_q};
      ssp_pkg::OFS_IRQ_EN: rmux = {13'h0000, ien_q};
      default:             rmux = 16'h0000;
    endcase
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (clk_en) begin
      rdata_q <= reg_rd ? rmux : 16'h0000;
    end
  end
  assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// [dv/sync_serial_port_props.sv]
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_props (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        irq,
  input wire logic        sclk_out,
  input wire logic        sclk_oe_n,
  input wire logic        fss_oe_n,
  input wire logic        sdo_oe_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Read data stands only in the slot after a read
  a_rdata_slot_only: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its slot");
  // Pins released and interrupt quiet while reset is held
  a_reset_pins_off: assert property (disable iff (1'h0)
    !rst_n |=> sdo_oe_n && sclk_oe_n && fss_oe_n && !irq)
    else $error("pins driven during reset");
  // Clock and frame pins are driven together, only as master
  a_master_pins_pair: assert property (
    sclk_oe_n == fss_oe_n)
    else $error("clock and frame enables differ");
  // Prescaler floor: a half period is never shorter than two cycles
  a_sclk_half_min: assert property (
    !sclk_oe_n && $changed(sclk_out) |=> $stable(sclk_out))
    else $error("serial clock half period too short");
  // Masking every event drops the interrupt
  a_irq_masked_off: assert property (
    reg_wr && reg_addr == ssp_pkg::OFS_IRQ_EN && reg_wdata[2:0] == 3'h0 |-> ##2 !irq)
    else $error("interrupt high with all events masked");
  // Clear register and unmapped slots read as zero
  a_wo_reads_zero: assert property (
    $past(reg_rd) && $past(reg_addr) >= ssp_pkg::OFS_IRQ_CLR |-> reg_rdata == 16'h0000)
    else $error("write-only or unmapped slot read nonzero");
  // Empty implies not full, full implies not empty
  a_status_coherent: assert property (
    reg_rd && reg_addr == ssp_pkg::OFS_STATUS |=> reg_rdata[15:5] == 11'h000
      && (reg_rdata[1] || !reg_rdata[0]) && (reg_rdata[2] || !reg_rdata[3]))
    else $error("status flags contradict");
  // Legal frame settings read back unchanged
  a_ctrl_readback: assert property (
    reg_wr && reg_addr == ssp_pkg::OFS_CTRL0 && reg_wdata[3:0] >= 4'h3
      ##1 reg_rd && reg_addr == ssp_pkg::OFS_CTRL0
      |=> reg_rdata == ($past(reg_wdata, 2) & 16'h00FF))
    else $error("frame setting readback differs");
endmodule
bind sync_serial_port sync_serial_port_props props (.*);
`default_nettype wire

// [dv/spi_slave_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Far-side peripheral: clock idles low, sample on rising, shift on falling
module spi_slave_model #(
  parameter int N = 8
) (
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  input  wire logic [15:0] tx_word,
  output logic             miso,
  output logic      [15:0] rx_word
);
  logic [15:0] sh;
  initial begin
    miso = 1'h0;
    rx_word = 16'h0000;
    sh = 16'h0000;
  end
  // Frame start loads an N-bit word, MSB first
  always @(negedge sel_n) begin
    sh = tx_word;
    rx_word = 16'h0000;
    miso = tx_word[N-1];
  end
  always @(posedge sclk) if (!sel_n) rx_word = {rx_word[14:0], mosi};
  always @(negedge sclk) begin
    if (!sel_n) begin
      sh = sh << 1;
      miso = sh[N-1];
    end
  end
  // Released line shows the inverse, never a stale bit
  always @(posedge sel_n) miso = ~miso;
endmodule
`default_nettype wire

// [dv/sync_serial_port_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_tb_top;
  logic        ref_clk;
  logic        rst_n;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        irq;
  logic        sclk_out, sclk_oe_n, fss_out, fss_oe_n, sdi, sdo, sdo_oe_n;
  logic [15:0] got;
  logic [15:0] peer_rx;
  int          mismatches;
  int          tests_run;
  // Line levels: frame pulled up, clock pulled down, data pulled up
  wire sclk_line = sclk_oe_n ? 1'h0 : sclk_out;
  wire fss_line  = fss_oe_n ? 1'h1 : fss_out;
  wire sdo_line  = sdo_oe_n ? 1'h1 : sdo;

  sync_serial_port dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'h1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .sclk_in(1'h0), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .fss_in(1'h1), .fss_out(fss_out), .fss_oe_n(fss_oe_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n)
  );
  spi_slave_model #(.N(8)) peer (
    .sclk(sclk_line), .sel_n(fss_line), .mosi(sdo_line), .tx_word(16'h00C3),
    .miso(sdi), .rx_word(peer_rx)
  );

  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One bus cycle; called just after a rising edge
  task automatic drive(input logic w, input logic r, input logic [3:0] a,
                       input logic [15:0] d);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    drive(1'h1, 1'h0, a, d);
  endtask
  // Strobe drops after the taking edge; data looked at in its one slot
  task automatic rd(input logic [3:0] a);
    drive(1'h0, 1'h1, a, 16'h0000);
    reg_rd <= 1'h0;
    @(negedge ref_clk);
    got = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    rd(a);
    chk(got, e);
  endtask
  // Pin triple: irq, data enable, clock enable
  task automatic pins(input logic [2:0] e);
    drive(1'h0, 1'h0, 4'h0, 16'h0000);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({13'h0000, irq, sdo_oe_n, sclk_oe_n}, {13'h0000, e});
    @(posedge ref_clk);
  endtask
  // Poll until transmit empty and not busy, bounded
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd(ssp_pkg::OFS_STATUS);
      n++;
    end while ((got[4] !== 1'h0 || got[0] !== 1'h1) && n < 400);
    if (n >= 400) mismatches++;
  endtask

  // Watchdog at 20000 cycles; whole sequence needs under a thousand cycles
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end

  initial begin
    logic [15:0] cfg;
    logic [15:0] msk;
    rst_n = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    mismatches = 0;
    tests_run = 0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'h1;
    // Reset values, then an unmapped slot
    rd_chk(ssp_pkg::OFS_CTRL0, {8'h00, ssp_pkg::CTRL0_RESET});
    rd_chk(ssp_pkg::OFS_PRESC, {8'h00, ssp_pkg::PRESC_RESET});
    rd_chk(ssp_pkg::OFS_DIV, {8'h00, ssp_pkg::DIV_RESET});
    rd_chk(ssp_pkg::OFS_STATUS, 16'h0003);
    rd_chk(4'hC, 16'h0000);
    // Master exchange with the peer, half bit of four cycles
    wr(ssp_pkg::OFS_DIV, 16'h0001);
    wr(ssp_pkg::OFS_CTRL1, 16'h0001);
    wr(ssp_pkg::OFS_DATA, 16'h00A5);
    wait_idle;
    pins(3'h0);
    rd_chk(ssp_pkg::OFS_DATA, 16'h00C3);
    chk(peer_rx, 16'h00A5);
    // Loopback in every format; shortest and longest frames
    wr(ssp_pkg::OFS_CTRL1, 16'h0009);
    for (int i = 0; i < 3; i++) begin
      cfg = 16'(i << 4) | ((i == 0) ? 16'h0003 : 16'h000F);
      msk = (i == 0) ? 16'h000F : 16'hFFFF;
      wr(ssp_pkg::OFS_CTRL0, cfg);
      rd_chk(ssp_pkg::OFS_CTRL0, cfg);
      wr(ssp_pkg::OFS_DATA, 16'hA5C3);
      wait_idle;
      rd_chk(ssp_pkg::OFS_DATA, 16'hA5C3 & msk);
    end
    // Nine words: receive side fills and overruns
    wr(ssp_pkg::OFS_CTRL0, 16'h0003);
    wr(ssp_pkg::OFS_IRQ_EN, 16'h0004);
    for (int i = 0; i < 9; i++) wr(ssp_pkg::OFS_DATA, 16'(i));
    wait_idle;
    rd_chk(ssp_pkg::OFS_STATUS, 16'h000F);
    pins(3'h6);
    rd_chk(ssp_pkg::OFS_IRQ_ST, 16'h0007);
    for (int i = 0; i < 8; i++) rd_chk(ssp_pkg::OFS_DATA, 16'(i));
    rd_chk(ssp_pkg::OFS_STATUS, 16'h0003);
    // Mask, unmask, then clear the overrun
    wr(ssp_pkg::OFS_IRQ_EN, 16'h0000);
    pins(3'h2);
    wr(ssp_pkg::OFS_IRQ_EN, 16'h0004);
    pins(3'h6);
    wr(ssp_pkg::OFS_IRQ_CLR, 16'h0007);
    rd_chk(ssp_pkg::OFS_IRQ_ST, 16'h0000);
    rd_chk(ssp_pkg::OFS_IRQ_CLR, 16'h0000);
    // Slave with its data output switched off
    wr(ssp_pkg::OFS_CTRL1, 16'h0007);
    pins(3'h3);
    end_sim();
  end
endmodule
`default_nettype wire
